// ===== core/adr_pkg.sv
/*
 Shared constants for the queued and extended DMA read command path:
 opcodes, task-file addresses, bit positions and the host's register map.
 Assumes one 100 MHz clock shared by both ends.
*/
package adr_pkg;
	localparam logic [7:0] OP_READ_EXT = 8'h25;
	localparam logic [7:0] OP_READ_QUEUED = 8'hC7;
	localparam logic [7:0] OP_SERVICE = 8'hA2;
	// Task-file addresses; 1 is feature on write and error on read, 7 command/status
	localparam logic [2:0] TF_FEATURE = 3'h1;
	localparam logic [2:0] TF_SECCNT = 3'h2;
	localparam logic [2:0] TF_SECNUM = 3'h3;
	localparam logic [2:0] TF_CYLLO = 3'h4;
	localparam logic [2:0] TF_CYLHI = 3'h5;
	localparam logic [2:0] TF_DEVHEAD = 3'h6;
	localparam logic [2:0] TF_COMMAND = 3'h7;
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_SERVICE = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_UNC = 6;
	localparam int ER_ABT = 2;
	localparam int DH_LBA = 6;
	localparam logic [2:0] SC_RELEASED = 3'h4;
	localparam logic [2:0] SC_COMPLETE = 3'h3;
	localparam logic [7:0] DH_EXT = 8'hE0;
	localparam logic [7:0] WORD_LAST = 8'hFF;
	localparam logic [16:0] SECS_EXT_ZERO = 17'h1_0000;
	localparam logic [16:0] SECS_Q_ZERO = 17'h0_0100;
	localparam logic [7:0] TF_RESET = 8'h00;
	localparam logic [7:0] WB_CTRL = 8'h00;
	localparam logic [7:0] WB_LBA_LO = 8'h04;
	localparam logic [7:0] WB_LBA_HI = 8'h08;
	localparam logic [7:0] WB_COUNT = 8'h0C;
	localparam logic [7:0] WB_RESULT = 8'h10;
	localparam logic [7:0] WB_FAIL_LO = 8'h14;
	localparam logic [7:0] WB_FAIL_HI = 8'h18;
	localparam logic [3:0] WR_LAST_STEP = 4'hA;
	localparam logic [3:0] RD_LAST_STEP = 4'h7;
	typedef enum logic [2:0] {D_IDLE, D_RELEASED, D_FETCH, D_XFER, D_DONE} adr_dstate_t;
	typedef enum logic [1:0] {H_IDLE, H_WR, H_WAIT, H_RD} adr_hstate_t;
endpackage

// ===== core/adr_if.sv
/*
 Task-file and slave-DMA link between host adapter and drive.
 Assumes both ends share clk_i; every signal is driven from a flip-flop.
*/
`timescale 1ns/1ps
`default_nettype none
interface adr_if;
	logic we;
	logic re;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic high_order_readback;
	logic dmack;
	logic [7:0] rdata;
	logic dmarq;
	logic [15:0] dma_data;
	logic intrq;
	modport dev (input we, re, addr, wdata, high_order_readback, dmack, output rdata, dmarq, dma_data, intrq);
	modport host (output we, re, addr, wdata, high_order_readback, dmack, input rdata, dmarq, dma_data, intrq);
endinterface
`default_nettype wire

// ===== core/adr_dev.sv
/*
 Drive end: task file, decode of the extended and queued DMA reads,
 bus release and service, and word pacing from the media to the host.
 Assumes the media streams words on request and flags uncorrectable sectors.
*/
// Notes on behaviour
// (RL1) Opcode 25h starts the extended read.
// (RL2) Opcode C7h starts the tagged queued read.
// (RL3) Media sectors go out as 16-bit words.
// (RL4) Host arms its DMA channel before the opcode; here dmack is enabled only in H_WAIT, after the opcode write.
// (RL5) Words move only while the request is high.
// (RL6) One interrupt per command, after final status.
// (RL7) Uncorrectable sector stops the read there.
// (RL8) Extended count 16 bits; zero means 65,536.
// (RL9) 48-bit address in current/previous bytes, readback-selected.
// (RL10) Queued read releases or transfers at once.
// (RL11) Host reselects with SERVICE after a release.
// (RL12) No release once the data phase starts.
// (RL13) Queued count from feature; zero means 256.
// (RL14) Tag taken from sector count bits 7-3.
// (RL15) Queued address: sector, cylinders, head bits.
// (RL16) Release: tag, release flag set, direction bits cleared.
// (RL17) Service flag cleared at release, set when ready.
// (RL18) Completion: tag, flags 011, service flag cleared.
// (RL19) Failing sector address left on queued error.
// (RL20) lba_select picks block or CHS addressing.
// (RL21) Outcome in error and status, busy clear.
`timescale 1ns/1ps
`default_nettype none
module adr_dev
	import adr_pkg::*;
(
	input wire logic clk_i, // 100 MHz clock
	input wire logic sys_rst_i, // async reset, active high
	adr_if.dev tf, // task file and DMA link
	output logic med_start_o, // pulse: start media read
	output logic [47:0] med_addr_o, // start address
	output logic med_lba_mode_o, // 1 block address, 0 CHS
	output logic [16:0] med_count_o, // sectors to read
	output logic med_ready_o, // word holder free
	input wire logic med_valid_i, // media word valid
	input wire logic [15:0] med_word_i, // media word
	input wire logic med_err_i, // uncorrectable sector
	input wire logic [47:0] med_err_addr_i, // failing sector address
	input wire logic data_ready_i // queued data already cached
);
	adr_dstate_t state_reg, state_next;
	logic [7:0] tf_cur [1:6];
	logic [7:0] tf_prev [1:6];
	logic queued_reg;
	logic [4:0] tag_reg;
	logic service_flag_reg;
	logic stop_reg;
	logic [7:0] err_reg;
	logic [16:0] sec_left_reg;
	logic [7:0] word_cnt_reg;
	logic full_next;
	logic cmd_wr;
	logic bad_cmd;
	logic release_event;
	logic word_taken;
	logic last_word;
	logic [15:0] ext_cnt;
	logic [7:0] status;

	assign cmd_wr = tf.we && tf.addr == TF_COMMAND;
	assign bad_cmd = tf.wdata != OP_READ_EXT && tf.wdata != OP_READ_QUEUED;
	assign release_event = state_reg == D_IDLE && cmd_wr && tf.wdata == OP_READ_QUEUED && !data_ready_i; // see (RL10)
	assign word_taken = state_reg == D_XFER && tf.dmack && tf.dmarq; // see (RL5)
	assign last_word = word_taken && word_cnt_reg == WORD_LAST && sec_left_reg == 17'h0_0001;
	assign ext_cnt = {tf_prev[TF_SECCNT], tf_cur[TF_SECCNT]}; // see (RL8)
	assign status = {state_reg == D_FETCH, 1'b1, 1'b0, service_flag_reg, state_reg == D_XFER, 2'b00, |err_reg}; // see (RL21)

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			D_IDLE: begin
				if (cmd_wr) begin
					if (tf.wdata == OP_READ_EXT) // see (RL1)
						state_next = D_FETCH;
					else if (tf.wdata == OP_READ_QUEUED) // see (RL2)
						state_next = data_ready_i ? D_FETCH : D_RELEASED; // see (RL10)
					else
						state_next = D_DONE;
				end
			end
			D_RELEASED: begin
				if (cmd_wr && tf.wdata == OP_SERVICE && service_flag_reg) // see (RL11)
					state_next = D_FETCH;
			end
			D_FETCH: state_next = D_XFER;
			// No path back to release once words flow; see (RL12)
			D_XFER: begin
				// A held word is still handed over after an error, so dmarq never drops under a pending dmack
				if (last_word || ((med_err_i || stop_reg) && (!tf.dmarq || word_taken))) // see (RL7)
					state_next = D_DONE;
			end
			D_DONE: state_next = D_IDLE;
			default: state_next = D_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			state_reg <= D_IDLE;
		else
			state_reg <= state_next;
	end

	// Writes land only in D_IDLE or D_RELEASED, so host writes and drive updates never collide
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 1; i <= 6; i++) begin
				tf_cur[i] <= TF_RESET;
				tf_prev[i] <= TF_RESET;
			end
		end else if (tf.we && tf.addr != TF_COMMAND && tf.addr != 3'h0 &&
			(state_reg == D_IDLE || state_reg == D_RELEASED)) begin
			tf_prev[tf.addr] <= tf_cur[tf.addr];
			tf_cur[tf.addr] <= tf.wdata;
		end else if (release_event) begin
			tf_cur[TF_SECCNT] <= {tf_cur[TF_SECCNT][7:3], SC_RELEASED}; // see (RL16)
		end else if (state_reg == D_XFER && med_err_i) begin
			tf_cur[TF_SECNUM] <= med_err_addr_i[7:0]; // see (RL9)
			tf_cur[TF_CYLLO] <= med_err_addr_i[15:8];
			tf_cur[TF_CYLHI] <= med_err_addr_i[23:16];
			tf_prev[TF_SECNUM] <= med_err_addr_i[31:24];
			tf_prev[TF_CYLLO] <= med_err_addr_i[39:32];
			tf_prev[TF_CYLHI] <= med_err_addr_i[47:40];
			if (queued_reg)
				tf_cur[TF_DEVHEAD][3:0] <= med_err_addr_i[27:24]; // see (RL19)
		end else if (state_reg == D_DONE && queued_reg) begin
			tf_cur[TF_SECCNT] <= {tag_reg, SC_COMPLETE}; // see (RL18)
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			queued_reg <= 1'b0;
			tag_reg <= 5'h00;
			sec_left_reg <= 17'h0_0000;
			err_reg <= 8'h00;
		end else if (state_reg == D_IDLE && cmd_wr) begin
			queued_reg <= tf.wdata == OP_READ_QUEUED;
			tag_reg <= tf_cur[TF_SECCNT][7:3]; // see (RL14)
			err_reg <= bad_cmd ? 8'h04 : 8'h00; // see (RL21)
			if (tf.wdata == OP_READ_QUEUED) // see (RL13)
				sec_left_reg <= tf_cur[TF_FEATURE] == 8'h00 ? SECS_Q_ZERO : {9'h000, tf_cur[TF_FEATURE]};
			else
				sec_left_reg <= ext_cnt == 16'h0000 ? SECS_EXT_ZERO : {1'b0, ext_cnt}; // see (RL8)
		end else if (state_reg == D_XFER && med_err_i) begin
			err_reg[ER_UNC] <= 1'b1;
		end else if (word_taken && word_cnt_reg == WORD_LAST) begin
			sec_left_reg <= sec_left_reg - 17'h0_0001;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			word_cnt_reg <= 8'h00;
		else if (state_reg == D_FETCH)
			word_cnt_reg <= 8'h00;
		else if (word_taken)
			word_cnt_reg <= word_cnt_reg + 8'h01;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			service_flag_reg <= 1'b0;
		else if (release_event || state_reg == D_DONE) // see (RL17)
			service_flag_reg <= 1'b0;
		else if (state_reg == D_RELEASED && data_ready_i)
			service_flag_reg <= 1'b1;
	end

	// No media word is accepted once a sector has failed
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			stop_reg <= 1'b0;
		else if (state_reg == D_DONE)
			stop_reg <= 1'b0;
		else if (state_reg == D_XFER && med_err_i) // see (RL7)
			stop_reg <= 1'b1;
	end

	// Set wins over the status-read clear so a late completion is never lost
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			tf.intrq <= 1'b0;
		else if (state_reg == D_DONE) // see (RL6)
			tf.intrq <= 1'b1;
		else if (tf.re && tf.addr == TF_COMMAND)
			tf.intrq <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tf.rdata <= 8'h00;
		end else begin
			unique case (tf.addr)
				3'h0: tf.rdata <= 8'h00;
				TF_FEATURE: tf.rdata <= err_reg;
				TF_COMMAND: tf.rdata <= status;
				default: tf.rdata <= tf.high_order_readback ? tf_prev[tf.addr] : tf_cur[tf.addr]; // see (RL9)
			endcase
		end
	end

	// A single word holder: the media stalls until the host has taken the last word
	always_comb begin
		full_next = tf.dmarq;
		if (tf.dmack)
			full_next = 1'b0;
		if (med_valid_i && med_ready_o)
			full_next = 1'b1;
		if (state_next != D_XFER) // see (RL7)
			full_next = 1'b0;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tf.dmarq <= 1'b0;
			tf.dma_data <= 16'h0000;
			med_ready_o <= 1'b0;
		end else begin
			tf.dmarq <= full_next; // see (RL5)
			med_ready_o <= state_next == D_XFER && !full_next && !med_err_i && !stop_reg; // see (RL7)
			if (med_valid_i && med_ready_o)
				tf.dma_data <= med_word_i; // see (RL3)
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			med_start_o <= 1'b0;
			med_addr_o <= 48'h0000_0000_0000;
			med_lba_mode_o <= 1'b0;
			med_count_o <= 17'h0_0000;
		end else begin
			med_start_o <= state_reg == D_FETCH;
			if (state_reg == D_FETCH) begin
				med_count_o <= sec_left_reg;
				if (queued_reg) begin // see (RL15)
					med_addr_o <= {20'h0_0000, tf_cur[TF_DEVHEAD][3:0], tf_cur[TF_CYLHI],
						tf_cur[TF_CYLLO], tf_cur[TF_SECNUM]};
					med_lba_mode_o <= tf_cur[TF_DEVHEAD][DH_LBA]; // see (RL20)
				end else begin
					med_addr_o <= {tf_prev[TF_CYLHI], tf_prev[TF_CYLLO], tf_prev[TF_SECNUM],
						tf_cur[TF_CYLHI], tf_cur[TF_CYLLO], tf_cur[TF_SECNUM]};
					med_lba_mode_o <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== core/adr_host.sv
/*
 Host adapter end: Wishbone register slave, task-file write sequence,
 service of released queued reads, slave DMA and result readback.
 Assumes the drive answers task-file reads one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module adr_host
	import adr_pkg::*;
(
	input wire logic clk_i, // 100 MHz clock
	input wire logic sys_rst_i, // async reset, active high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [3:0] wb_sel_i, // byte lanes
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	adr_if.host tf, // task file and DMA link
	output logic [15:0] data_o, // received word
	output logic data_valid_o, // pulse: data_o valid
	input wire logic data_ready_i // sink can take a word
);
	adr_hstate_t state_reg;
	logic [3:0] step_reg;
	logic [1:0] ph_reg;
	logic queued_reg, lba_reg, serviced_reg;
	logic [47:0] addr_reg, fail_reg;
	logic [15:0] count_reg;
	logic [4:0] tag_reg;
	logic [7:0] st_cap, er_cap;
	logic [31:0] mask;
	logic wb_wr;

	assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	function automatic logic [10:0] wr_item(input logic [3:0] s, input logic q);
		unique case (s)
			4'h0: wr_item = {TF_FEATURE, q ? count_reg[7:0] : 8'h00};
			4'h1: wr_item = {TF_SECCNT, q ? {tag_reg, 3'h0} : count_reg[15:8]};
			4'h2: wr_item = {TF_SECCNT, q ? {tag_reg, 3'h0} : count_reg[7:0]};
			4'h3: wr_item = {TF_SECNUM, q ? addr_reg[7:0] : addr_reg[31:24]};
			4'h4: wr_item = {TF_SECNUM, addr_reg[7:0]};
			4'h5: wr_item = {TF_CYLLO, q ? addr_reg[15:8] : addr_reg[39:32]};
			4'h6: wr_item = {TF_CYLLO, addr_reg[15:8]};
			4'h7: wr_item = {TF_CYLHI, q ? addr_reg[23:16] : addr_reg[47:40]};
			4'h8: wr_item = {TF_CYLHI, addr_reg[23:16]};
			4'h9: wr_item = {TF_DEVHEAD, q ? {1'b1, lba_reg, 2'b10, addr_reg[27:24]} : DH_EXT};
			default: wr_item = {TF_COMMAND, q ? OP_READ_QUEUED : OP_READ_EXT};
		endcase
	endfunction

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (wb_adr_i)
				WB_CTRL: wb_dat_o <= {28'h000_0000, st_cap[ST_ERR], lba_reg, queued_reg, state_reg != H_IDLE};
				WB_LBA_LO: wb_dat_o <= addr_reg[31:0];
				WB_LBA_HI: wb_dat_o <= {16'h0000, addr_reg[47:32]};
				WB_COUNT: wb_dat_o <= {11'h000, tag_reg, count_reg};
				WB_RESULT: wb_dat_o <= {16'h0000, er_cap, st_cap};
				WB_FAIL_LO: wb_dat_o <= fail_reg[31:0];
				WB_FAIL_HI: wb_dat_o <= {16'h0000, fail_reg[47:32]};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Parameters are frozen while a command runs
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			queued_reg <= 1'b0;
			lba_reg <= 1'b0;
			addr_reg <= 48'h0000_0000_0000;
			count_reg <= 16'h0000;
			tag_reg <= 5'h00;
		end else if (wb_wr && state_reg == H_IDLE) begin
			unique case (wb_adr_i)
				WB_CTRL: begin
					if (wb_sel_i[0]) begin
						queued_reg <= wb_dat_i[1];
						lba_reg <= wb_dat_i[2];
					end
				end
				WB_LBA_LO: addr_reg[31:0] <= (addr_reg[31:0] & ~mask) | (wb_dat_i & mask);
				WB_LBA_HI: addr_reg[47:32] <= (addr_reg[47:32] & ~mask[15:0]) | (wb_dat_i[15:0] & mask[15:0]);
				WB_COUNT: begin
					count_reg <= (count_reg & ~mask[15:0]) | (wb_dat_i[15:0] & mask[15:0]);
					if (wb_sel_i[2])
						tag_reg <= wb_dat_i[20:16];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= H_IDLE;
			step_reg <= 4'h0;
			ph_reg <= 2'h0;
			serviced_reg <= 1'b0;
			tf.we <= 1'b0;
			tf.re <= 1'b0;
			tf.addr <= TF_COMMAND;
			tf.wdata <= 8'h00;
			tf.high_order_readback <= 1'b0;
			st_cap <= 8'h00;
			er_cap <= 8'h00;
			fail_reg <= 48'h0000_0000_0000;
		end else begin
			tf.we <= 1'b0;
			tf.re <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					tf.addr <= TF_COMMAND;
					tf.high_order_readback <= 1'b0;
					if (wb_wr && wb_adr_i == WB_CTRL && wb_sel_i[0] && wb_dat_i[0]) begin
						state_reg <= H_WR;
						step_reg <= 4'h0;
						serviced_reg <= 1'b0;
					end
				end
				H_WR: begin
					tf.we <= 1'b1;
					{tf.addr, tf.wdata} <= wr_item(step_reg, queued_reg);
					step_reg <= step_reg + 4'h1;
					if (step_reg == WR_LAST_STEP)
						state_reg <= H_WAIT;
				end
				H_WAIT: begin
					tf.addr <= TF_COMMAND;
					if (tf.intrq) begin
						state_reg <= H_RD;
						step_reg <= 4'h0;
						ph_reg <= 2'h0;
					end else if (queued_reg && !serviced_reg && tf.rdata[ST_SERVICE] && !tf.dmarq) begin
						tf.we <= 1'b1;
						tf.wdata <= OP_SERVICE;
						serviced_reg <= 1'b1;
					end
				end
				H_RD: begin
					ph_reg <= ph_reg + 2'h1;
					if (ph_reg == 2'h0) begin
						tf.addr <= step_reg == 4'h0 ? TF_COMMAND : step_reg == 4'h1 ? TF_FEATURE : 3'(step_reg[3:1] + 3'h2);
						tf.high_order_readback <= step_reg > 4'h1 && step_reg[0];
						tf.re <= step_reg == 4'h0;
					end else if (ph_reg == 2'h2) begin
						ph_reg <= 2'h0;
						step_reg <= step_reg + 4'h1;
						unique case (step_reg)
							4'h0: st_cap <= tf.rdata;
							4'h1: er_cap <= tf.rdata;
							4'h2: fail_reg[7:0] <= tf.rdata;
							4'h3: fail_reg[31:24] <= tf.rdata;
							4'h4: fail_reg[15:8] <= tf.rdata;
							4'h5: fail_reg[39:32] <= tf.rdata;
							4'h6: fail_reg[23:16] <= tf.rdata;
							default: fail_reg[47:40] <= tf.rdata;
						endcase
						if (step_reg == RD_LAST_STEP)
							state_reg <= H_IDLE;
					end
				end
			endcase
		end
	end

	// The DMA channel is enabled only in H_WAIT, after the write sequence has sent the opcode
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tf.dmack <= 1'b0;
			data_o <= 16'h0000;
			data_valid_o <= 1'b0;
		end else begin
			tf.dmack <= state_reg == H_WAIT && tf.dmarq && !tf.dmack && data_ready_i;
			data_valid_o <= tf.dmack;
			if (tf.dmack)
				data_o <= tf.dma_data;
		end
	end
endmodule
`default_nettype wire

// ===== test/adr_props.sv
/*
 Checker for the task-file and DMA link joining the host and drive ends.
 Assumes the bench instantiates it beside the interface and feeds it the interface's signals.
*/
`timescale 1ns/1ps
`default_nettype none
module adr_props
	import adr_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic sys_rst_i, // async reset
	input wire logic we, // task-file write
	input wire logic re, // status read
	input wire logic [2:0] addr, // register address
	input wire logic [7:0] wdata, // write data
	input wire logic high_order_readback, // readback select
	input wire logic dmack, // host takes word
	input wire logic [7:0] rdata, // read data
	input wire logic dmarq, // word held
	input wire logic [15:0] dma_data, // held word
	input wire logic intrq // command finished
);
	logic cmd_open_reg;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Open from a command write to the first interrupt edge; a later edge with no new command is a duplicate
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cmd_open_reg <= 1'b0;
		end else if (we && addr == TF_COMMAND) begin
			cmd_open_reg <= 1'b1;
		end else if ($rose(intrq)) begin
			cmd_open_reg <= 1'b0;
		end
	end
	sequence s_status_rd;
		re && addr == TF_COMMAND;
	endsequence
	sequence s_ext_cmd;
		we && addr == TF_COMMAND && wdata == OP_READ_EXT;
	endsequence
	sequence s_q_cmd;
		we && addr == TF_COMMAND && wdata == OP_READ_QUEUED;
	endsequence
	property p_dmack_rq;
		dmack |-> dmarq;
	endproperty
	property p_rq_drop;
		dmack |=> !dmarq;
	endproperty
	property p_word_hold;
		dmarq && !dmack |=> dmarq && $stable(dma_data);
	endproperty
	property p_irq_hold;
		intrq && !(re && addr == TF_COMMAND) |=> intrq;
	endproperty
	property p_irq_clear;
		s_status_rd ##0 intrq |=> !intrq;
	endproperty
	property p_irq_idle;
		intrq |-> !dmarq;
	endproperty
	property p_cmd_armed;
		we && addr == TF_COMMAND |-> !dmarq && !dmack;
	endproperty
	property p_ext_quiet;
		s_ext_cmd |=> !intrq [*2];
	endproperty
	property p_q_quiet;
		s_q_cmd |=> !intrq [*2];
	endproperty
	property p_rq_in_cmd;
		$rose(dmarq) |-> cmd_open_reg;
	endproperty
	property p_one_irq;
		$rose(intrq) |-> cmd_open_reg;
	endproperty
	a_dmack_rq: assert property (p_dmack_rq) else $error("dmack without dmarq");
	a_rq_drop: assert property (p_rq_drop) else $error("dmarq held after dmack");
	a_word_hold: assert property (p_word_hold) else $error("held word changed");
	a_irq_hold: assert property (p_irq_hold) else $error("intrq dropped unread");
	a_irq_clear: assert property (p_irq_clear) else $error("status read left intrq");
	a_irq_idle: assert property (p_irq_idle) else $error("intrq during data");
	a_cmd_armed: assert property (p_cmd_armed) else $error("command during DMA");
	a_ext_quiet: assert property (p_ext_quiet) else $error("early intrq, extended");
	a_q_quiet: assert property (p_q_quiet) else $error("early intrq, queued");
	a_rq_in_cmd: assert property (p_rq_in_cmd) else $error("dmarq outside command");
	a_one_irq: assert property (p_one_irq) else $error("second interrupt");
endmodule
`default_nettype wire

// ===== test/testbench.sv
/*
 Bench joining the host and drive ends; Wishbone orders in, media words and errors in.
 Assumes a media word is taken at an edge where valid and ready are both high.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
	import adr_pkg::*;
;
	logic clk_i, sys_rst_i, wb_cyc, wb_stb, wb_we, wb_ack, med_start, med_lba, med_ready, med_valid, med_err;
	logic q_ready, sink_ready, data_valid, st_lba, err_done;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_rdat;
	logic [15:0] med_word, data_w, word_base;
	logic [16:0] med_count, st_cnt;
	logic [47:0] med_addr, med_err_addr, st_addr, lba_v, fail_v;
	int n_fail = 0, cmp_count = 0, seed = 3, cyc_n = 0, med_idx = 0, med_total = 0, err_at = -1, rx_idx = 0, n_start = 0;
	adr_if adr_if_i();
	adr_dev adr_dev_i(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tf(adr_if_i), .med_start_o(med_start),
		.med_addr_o(med_addr), .med_lba_mode_o(med_lba), .med_count_o(med_count), .med_ready_o(med_ready),
		.med_valid_i(med_valid), .med_word_i(med_word), .med_err_i(med_err), .med_err_addr_i(med_err_addr),
		.data_ready_i(q_ready));
	adr_host adr_host_i(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .tf(adr_if_i), .data_o(data_w), .data_valid_o(data_valid), .data_ready_i(sink_ready));
	adr_props adr_props_i(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .we(adr_if_i.we), .re(adr_if_i.re),
		.addr(adr_if_i.addr), .wdata(adr_if_i.wdata), .high_order_readback(adr_if_i.high_order_readback),
		.dmack(adr_if_i.dmack),
		.rdata(adr_if_i.rdata), .dmarq(adr_if_i.dmarq), .dma_data(adr_if_i.dma_data), .intrq(adr_if_i.intrq));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [15:0] exp_word(input int i);
		return word_base ^ (16'(i) * 16'h9E37);
	endfunction
	task end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task check(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_sel <= 4'hF;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cyc_n = cyc_n + 1;
	end
	// Ceiling several times the expected run length; a hang ends as a failure
	initial begin
		wait (cyc_n == 30000);
		n_fail = n_fail + 1;
		end_sim();
	end
	// Media source with random stalls, one error pulse at word err_at, host sink stalling at random
	always @(posedge clk_i) begin
		if (med_valid && med_ready === 1'b1) med_idx = med_idx + 1;
		if (data_valid === 1'b1) begin
			check(data_w, exp_word(rx_idx));
			rx_idx = rx_idx + 1;
		end
		if (med_start === 1'b1) begin
			st_addr = med_addr;
			st_cnt = med_count;
			st_lba = med_lba;
			n_start = n_start + 1;
		end
		sink_ready <= ($random(seed) % 4) != 0;
		med_err <= 1'b0;
		if (med_idx == err_at && med_ready === 1'b1 && !err_done) begin
			med_err <= 1'b1;
			med_valid <= 1'b0;
			err_done = 1'b1;
		end else begin
			med_valid <= med_idx < med_total && ($random(seed) % 3) != 0;
			med_word <= exp_word(med_idx);
		end
	end
	task run(input logic q, input logic lba, input logic release_bus, input logic [15:0] cnt, input int total, input int err);
		logic [31:0] r;
		med_idx = 0;
		med_total = total;
		err_at = err;
		err_done = 1'b0;
		rx_idx = 0;
		n_start = 0;
		word_base = 16'($random(seed));
		lba_v[31:0] = $random(seed);
		lba_v[47:32] = 16'($random(seed));
		med_err_addr[31:0] <= $random(seed);
		med_err_addr[47:32] <= 16'($random(seed));
		q_ready <= !release_bus;
		wb(1'b1, WB_LBA_LO, lba_v[31:0], r);
		wb(1'b1, WB_LBA_HI, {16'h0000, lba_v[47:32]}, r);
		wb(1'b1, WB_COUNT, {11'h000, 5'($random(seed)), cnt}, r);
		wb(1'b1, WB_CTRL, {29'h0000_0000, lba, q, 1'b1}, r);
		if (release_bus) begin
			repeat (40) @(posedge clk_i);
			check(48'(n_start + rx_idx), 48'h0);
			q_ready <= 1'b1;
		end
		do begin
			wb(1'b0, WB_CTRL, 32'h0000_0000, r);
		end while (r[0] !== 1'b0);
		check(48'(n_start), 48'h1);
		wb(1'b0, WB_RESULT, 32'h0000_0000, r);
		check(r[ST_BSY], 1'b0);
		check(r[ST_RDY], 1'b1);
		check(r[ST_SERVICE], 1'b0);
		check(r[ST_ERR], err >= 0);
		check(r[8 + ER_UNC], err >= 0);
		wb(1'b0, WB_FAIL_LO, 32'h0000_0000, r);
		fail_v[31:0] = r;
		wb(1'b0, WB_FAIL_HI, 32'h0000_0000, r);
		fail_v[47:32] = r[15:0];
	endtask
	initial begin
		logic [31:0] r;
		sys_rst_i = 1'b1;
		{wb_cyc, wb_stb, wb_we, med_valid, med_err, err_done} = 6'h00;
		{q_ready, sink_ready} = 2'h3;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0000_0000;
		med_word = 16'h0000;
		med_err_addr = 48'h0000_0000_0000;
		word_base = 16'h0000;
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF, r);
		wb(1'b0, 8'h40, 32'h0000_0000, r);
		check(r, 48'h0);
		for (int i = 1; i <= 2; i++) begin
			run(1'b0, 1'b1, 1'b0, 16'(i), 256 * i, -1);
			check(st_cnt, 17'(i));
			check(st_addr, lba_v);
			check(st_lba, 1'b1);
			check(48'(rx_idx), 48'(256 * i));
		end
		run(1'b0, 1'b1, 1'b0, 16'h0000, 0, 0);
		check(st_cnt, 17'h1_0000);
		check(fail_v, med_err_addr);
		check(48'(rx_idx), 48'h0);
		run(1'b0, 1'b1, 1'b0, 16'h0003, 300, 300);
		check(st_cnt, 17'h0_0003);
		check(rx_idx >= 256 && rx_idx <= 300, 1'b1);
		check(fail_v, med_err_addr);
		run(1'b1, 1'b1, 1'b1, 16'h0001, 256, -1);
		check(st_cnt, 17'h0_0001);
		check(st_addr, {20'h0_0000, lba_v[27:0]});
		check(48'(rx_idx), 48'h100);
		run(1'b1, 1'b0, 1'b0, 16'h0000, 0, 0);
		check(st_cnt, 17'h0_0100);
		check(st_lba, 1'b0);
		check(fail_v[27:0], med_err_addr[27:0]);
		end_sim();
	end
endmodule
`default_nettype wire
